//--- src/sxa_map.svh
// Purpose: register map, instruction fields and reset values of the status/ALU unit
// Assumes: byte addresses on an APB bus with 32-bit data
// Notes: field macros are part-select ranges or bit indices
`ifndef SXA_MAP_SVH
`define SXA_MAP_SVH
`define SXA_A_INSN 8'h00
`define SXA_A_OPNDA 8'h04
`define SXA_A_SHOP 8'h08
`define SXA_A_SHC 8'h0C
`define SXA_A_MCAND 8'h10
`define SXA_A_MPLIER 8'h14
`define SXA_A_RESULT 8'h18
`define SXA_A_STAT 8'h1C
`define SXA_A_CSW 8'h20
`define SXA_A_SSW 8'h24
`define SXA_A_PC 8'h28
`define SXA_F_COND 31:28
`define SXA_F_CLASS 27:26
`define SXA_F_MULZ 27:22
`define SXA_F_IBIT 25
`define SXA_F_DPOP 24:21
`define SXA_F_MSRHI 24:23
`define SXA_F_RBIT 22
`define SXA_F_MSRLO 21:20
`define SXA_F_SBIT 20
`define SXA_F_MASK 19:16
`define SXA_F_MRD 19:16
`define SXA_F_RD 15:12
`define SXA_F_ROT 11:8
`define SXA_F_MULTAG 7:4
`define SXA_F_IMM 7:0
`define SXA_F_MODE 4:0
`define SXA_F_CV 29:28
`define SXA_FN 31
`define SXA_FZ 30
`define SXA_FC 29
`define SXA_FV 28
`define SXA_PC_IDX 4'hF
`define SXA_MODE_USR 5'h10
`define SXA_MODE_SYS 5'h1F
`define SXA_CSW_RST 32'h0000_0013
`define SXA_OPC_MVN 4'hF
`define SXA_OPC_ORR 4'hC
`define SXA_OPC_RSB 4'h3
`define SXA_OPC_RSC 4'h7
`define SXA_OPC_SBC 4'h6
`define SXA_MULTAG 4'h9
`define SXA_MSRHI 2'h2
`define SXA_MSRLO 2'h2
`endif

//--- src/sxa_pkg.sv
// Purpose: types shared by the status/ALU unit
// Assumes: constants live in sxa_map.svh
// Notes: each module keeps its whole state in one packed struct
package sxa_pkg;
   typedef enum logic [1:0] {SXA_IDLE = 2'b00, SXA_EXEC = 2'b01, SXA_MULW = 2'b10} sxa_state_t;
   typedef enum logic [2:0]
   {
      SXA_OP_NONE = 3'b000, SXA_OP_MSR = 3'b001, SXA_OP_MUL = 3'b010, SXA_OP_MVN = 3'b011,
      SXA_OP_ORR = 3'b100, SXA_OP_RSB = 3'b101, SXA_OP_RSC = 3'b110, SXA_OP_SBC = 3'b111
   } sxa_op_t;
   typedef struct packed {
      sxa_state_t state;
      logic [31:0] insn;
      logic [31:0] opnd_a;
      logic [31:0] shop;
      logic shc;
      logic [31:0] mcand;
      logic [31:0] mplier;
      logic [31:0] result;
      logic [31:0] csw;
      logic [31:0] ssw;
      logic [31:0] pc;
      logic [3:0] dest;
      logic exe;
      logic pcw;
      logic wb;
      logic mstart;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } sxa_core_st_t;
   typedef struct packed {
      logic [31:0] acc;
      logic [31:0] a;
      logic [31:0] b;
      logic busy;
      logic done;
   } sxa_mul_st_t;
endpackage

//--- src/sxa_mul_if.sv
// Purpose: request and answer between the core and the multiplier
// Assumes: one clock, start is a one-cycle pulse
// Notes: done is a one-cycle pulse with product valid in the same cycle
`timescale 1ns/1ps
interface sxa_mul_if;
   logic start;
   logic [31:0] mcand;
   logic [31:0] mplier;
   logic done;
   logic [31:0] product;
   modport req (output start, output mcand, output mplier, input done, input product);
   modport unit (input start, input mcand, input mplier, output done, output product);
endinterface

//--- src/sxa_cond.sv
// Purpose: condition field evaluation against the current flags
// Assumes: flags_i is {N, Z, C, V}
// Notes: purely combinational
`timescale 1ns/1ps
module sxa_cond (
   // Condition and flags
   input wire logic [3:0] cond_i,
   input wire logic [3:0] flags_i,
   // Verdict
   output logic pass_o
);
   import sxa_pkg::*;
   logic n, z, c, v;
   assign {n, z, c, v} = flags_i;
   always_comb
   begin
      unique case (cond_i)
         4'h0: pass_o = z;
         4'h1: pass_o = !z;
         4'h2: pass_o = c;
         4'h3: pass_o = !c;
         4'h4: pass_o = n;
         4'h5: pass_o = !n;
         4'h6: pass_o = v;
         4'h7: pass_o = !v;
         4'h8: pass_o = c && !z;
         4'h9: pass_o = !c || z;
         4'hA: pass_o = n == v;
         4'hB: pass_o = n != v;
         4'hC: pass_o = !z && (n == v);
         4'hD: pass_o = z || (n != v);
         4'hE: pass_o = 1'b1;
         // Never form: treated as a no-op
         4'hF: pass_o = 1'b0;
      endcase
   end
endmodule

//--- src/sxa_mul.sv
// Purpose: iterative 32x32 multiplier returning the low word
// Assumes: start only while idle
// Notes: one multiplier byte per cycle, 1 to 4 cycles
`timescale 1ns/1ps
module sxa_mul (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Request from the core
   sxa_mul_if.unit m
);
   import sxa_pkg::*;
   sxa_mul_st_t st_q, st_d;
   logic [31:0] part;

   assign m.done = st_q.done;
   assign m.product = st_q.acc;

   always_comb
   begin
      st_d = st_q;
      st_d.done = 1'b0;
      part = 32'(st_q.a * {24'h00_0000, st_q.b[7:0]});
      if (st_q.busy)
      begin
         st_d.acc = st_q.acc + part;
         st_d.a = {st_q.a[23:0], 8'h00};
         st_d.b = {8'h00, st_q.b[31:8]};
         // Unsigned early termination on the multiplier operand
         if (st_q.b[31:8] == 24'h00_0000)
         begin
            st_d.busy = 1'b0;
            st_d.done = 1'b1;
         end
      end
      else if (m.start)
      begin
         st_d.acc = 32'h0000_0000;
         st_d.a = m.mcand;
         st_d.b = m.mplier;
         st_d.busy = 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   mul_term_a: assert property (@(posedge clk_i) disable iff (rst_i)
      m.start && !st_q.busy |-> ##[2:5] m.done)
      else $error("multiplier did not finish within four steps");
endmodule

//--- src/sxa_core.sv
// Purpose: status write, multiply and ALU operations behind an APB slave
// Assumes: single master, one instruction in flight, operands loaded first
// Notes: writing the instruction register starts execution
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "sxa_map.svh"

module sxa_core (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // APB slave
   input wire logic [7:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Execution results
   output logic wb_valid_o,
   output logic [3:0] wb_dest_o,
   output logic [31:0] result_o,
   output logic [31:0] pc_o,
   output logic [31:0] csw_o
);
   import sxa_pkg::*;
   sxa_core_st_t st_q, st_d;
   sxa_mul_if mif ();
   sxa_op_t op;
   logic cond_ok, priv, has_ssw, is_user, sflag, ibit, sh_c, hit, ro;
   logic [4:0] rot;
   logic [31:0] imm_rot, sh_v, msr_opnd, alu_res, sub_a, sub_b, rd_val;
   logic [32:0] diff;
   logic sub_ci, alu_c, alu_v;
   logic [3:0] rd;

   sxa_cond u_cond (
      .cond_i (st_q.insn[`SXA_F_COND]),
      .flags_i (st_q.csw[31:28]),
      .pass_o (cond_ok)
   );

   sxa_mul u_mul (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .m (mif.unit)
   );

   assign mif.start = st_q.mstart;
   assign mif.mcand = st_q.mcand;
   assign mif.mplier = st_q.mplier;

   // Decode
   always_comb
   begin
      op = SXA_OP_NONE;
      if (st_q.insn[`SXA_F_MULZ] == 6'h00 && st_q.insn[`SXA_F_MULTAG] == `SXA_MULTAG)
         op = SXA_OP_MUL;
      else if (st_q.insn[`SXA_F_CLASS] == 2'h0 && st_q.insn[`SXA_F_MSRHI] == `SXA_MSRHI
               && st_q.insn[`SXA_F_MSRLO] == `SXA_MSRLO)
         op = SXA_OP_MSR;
      else if (st_q.insn[`SXA_F_CLASS] == 2'h0)
      begin
         unique case (st_q.insn[`SXA_F_DPOP])
            `SXA_OPC_MVN: op = SXA_OP_MVN;
            `SXA_OPC_ORR: op = SXA_OP_ORR;
            `SXA_OPC_RSB: op = SXA_OP_RSB;
            `SXA_OPC_RSC: op = SXA_OP_RSC;
            `SXA_OPC_SBC: op = SXA_OP_SBC;
            default: op = SXA_OP_NONE;
         endcase
      end
   end

   assign ibit = st_q.insn[`SXA_F_IBIT];
   assign sflag = st_q.insn[`SXA_F_SBIT];
   assign rd = (op == SXA_OP_MUL) ? st_q.insn[`SXA_F_MRD] : st_q.insn[`SXA_F_RD];
   assign is_user = st_q.csw[`SXA_F_MODE] == `SXA_MODE_USR;
   assign priv = !is_user;
   // System mode shares user registers and owns no saved word
   assign has_ssw = priv && st_q.csw[`SXA_F_MODE] != `SXA_MODE_SYS;

   // Immediate operand rotation and operand select
   always_comb
   begin
      rot = {st_q.insn[`SXA_F_ROT], 1'b0};
      imm_rot = 32'({2{24'h00_0000, st_q.insn[`SXA_F_IMM]}} >> rot);
      sh_v = ibit ? imm_rot : st_q.shop;
      sh_c = ibit ? ((rot == 5'h00) ? st_q.csw[`SXA_FC] : imm_rot[31]) : st_q.shc;
      msr_opnd = ibit ? imm_rot : st_q.mcand;
   end

   // Shared subtractor: a + ~b + ci gives carry as inverted borrow
   always_comb
   begin
      sub_a = sh_v;
      sub_b = st_q.opnd_a;
      sub_ci = 1'b1;
      unique case (op)
         SXA_OP_RSC: sub_ci = st_q.csw[`SXA_FC];
         SXA_OP_SBC:
         begin
            sub_a = st_q.opnd_a;
            sub_b = sh_v;
            sub_ci = st_q.csw[`SXA_FC];
         end
         SXA_OP_NONE, SXA_OP_MSR, SXA_OP_MUL, SXA_OP_MVN, SXA_OP_ORR, SXA_OP_RSB: sub_ci = 1'b1;
      endcase
      diff = {1'b0, sub_a} + {1'b0, ~sub_b} + {32'h0000_0000, sub_ci};
      alu_res = diff[31:0];
      alu_c = diff[32];
      alu_v = (sub_a[31] != sub_b[31]) && (diff[31] != sub_a[31]);
      if (op == SXA_OP_MVN)
      begin
         alu_res = ~sh_v;
         alu_c = sh_c;
         alu_v = st_q.csw[`SXA_FV];
      end
      else if (op == SXA_OP_ORR)
      begin
         alu_res = st_q.opnd_a | sh_v;
         alu_c = sh_c;
         alu_v = st_q.csw[`SXA_FV];
      end
   end

   // Register decode and read data
   always_comb
   begin
      hit = 1'b1;
      ro = 1'b0;
      rd_val = 32'h0000_0000;
      unique case (paddr_i)
         `SXA_A_INSN: rd_val = st_q.insn;
         `SXA_A_OPNDA: rd_val = st_q.opnd_a;
         `SXA_A_SHOP: rd_val = st_q.shop;
         `SXA_A_SHC: rd_val = {31'h0000_0000, st_q.shc};
         `SXA_A_MCAND: rd_val = st_q.mcand;
         `SXA_A_MPLIER: rd_val = st_q.mplier;
         `SXA_A_CSW: rd_val = st_q.csw;
         `SXA_A_SSW: rd_val = st_q.ssw;
         `SXA_A_PC: rd_val = st_q.pc;
         `SXA_A_RESULT:
         begin
            rd_val = st_q.result;
            ro = 1'b1;
         end
         `SXA_A_STAT:
         begin
            rd_val = {20'h0_0000, st_q.dest, 5'h00, st_q.pcw, st_q.exe, st_q.state != SXA_IDLE};
            ro = 1'b1;
         end
         default: hit = 1'b0;
      endcase
   end

   always_comb
   begin
      st_d = st_q;
      st_d.pready = 1'b0;
      st_d.wb = 1'b0;
      st_d.mstart = 1'b0;
      // First access cycle: decide the answer; the next edge commits it
      if (psel_i && penable_i && !st_q.pready)
      begin
         st_d.pready = 1'b1;
         st_d.pslverr = !hit || (pwrite_i && (ro || st_q.state != SXA_IDLE));
         st_d.prdata = pwrite_i ? 32'h0000_0000 : rd_val;
      end
      if (psel_i && penable_i && st_q.pready && pwrite_i && !st_q.pslverr)
      begin
         unique case (paddr_i)
            `SXA_A_INSN:
            begin
               st_d.insn = pwdata_i;
               st_d.state = SXA_EXEC;
               st_d.exe = 1'b0;
               st_d.pcw = 1'b0;
            end
            `SXA_A_OPNDA: st_d.opnd_a = pwdata_i;
            `SXA_A_SHOP: st_d.shop = pwdata_i;
            `SXA_A_SHC: st_d.shc = pwdata_i[0];
            `SXA_A_MCAND: st_d.mcand = pwdata_i;
            `SXA_A_MPLIER: st_d.mplier = pwdata_i;
            `SXA_A_CSW: st_d.csw = pwdata_i;
            `SXA_A_SSW: st_d.ssw = pwdata_i;
            `SXA_A_PC: st_d.pc = pwdata_i;
            default: st_d.pc = st_q.pc;
         endcase
      end
      unique case (st_q.state)
         SXA_IDLE: st_d.state = st_d.state;
         SXA_EXEC:
         begin
            st_d.state = SXA_IDLE;
            if (cond_ok)
            begin
               st_d.exe = 1'b1;
               st_d.dest = rd;
               unique case (op)
                  SXA_OP_NONE: st_d.exe = 1'b1;
                  SXA_OP_MUL:
                  begin
                     st_d.mstart = 1'b1;
                     st_d.state = SXA_MULW;
                  end
                  SXA_OP_MSR:
                  begin
                     for (int i = 0; i < 4; i++)
                     begin
                        if (st_q.insn[16 + i])
                        begin
                           if (st_q.insn[`SXA_F_RBIT])
                           begin
                              if (has_ssw)
                                 st_d.ssw[8 * i +: 8] = msr_opnd[8 * i +: 8];
                           end
                           else if (priv || i == 3)
                              st_d.csw[8 * i +: 8] = msr_opnd[8 * i +: 8];
                        end
                     end
                  end
                  SXA_OP_MVN, SXA_OP_ORR, SXA_OP_RSB, SXA_OP_RSC, SXA_OP_SBC:
                  begin
                     st_d.result = alu_res;
                     if (rd == `SXA_PC_IDX)
                     begin
                        st_d.pc = alu_res;
                        st_d.pcw = 1'b1;
                        // No saved word in user/system: the restore is skipped
                        if (sflag && has_ssw)
                           st_d.csw = st_q.ssw;
                     end
                     else
                     begin
                        st_d.wb = 1'b1;
                        if (sflag)
                        begin
                           st_d.csw[`SXA_FN] = alu_res[31];
                           st_d.csw[`SXA_FZ] = alu_res == 32'h0000_0000;
                           st_d.csw[`SXA_FC] = alu_c;
                           st_d.csw[`SXA_FV] = alu_v;
                        end
                     end
                  end
               endcase
            end
         end
         SXA_MULW:
         begin
            if (mif.done)
            begin
               st_d.state = SXA_IDLE;
               st_d.result = mif.product;
               st_d.wb = 1'b1;
               // C and V are left as they were
               if (sflag)
               begin
                  st_d.csw[`SXA_FN] = mif.product[31];
                  st_d.csw[`SXA_FZ] = mif.product == 32'h0000_0000;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_q <= '0;
         st_q.csw <= `SXA_CSW_RST;
      end
      else
         st_q <= st_d;
   end

   assign prdata_o = st_q.prdata;
   assign pready_o = st_q.pready;
   assign pslverr_o = st_q.pslverr;
   assign wb_valid_o = st_q.wb;
   assign wb_dest_o = st_q.dest;
   assign result_o = st_q.result;
   assign pc_o = st_q.pc;
   assign csw_o = st_q.csw;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   logic exec_ok, dp_op;
   assign exec_ok = st_q.state == SXA_EXEC && cond_ok;
   assign dp_op = op inside {SXA_OP_MVN, SXA_OP_ORR, SXA_OP_RSB, SXA_OP_RSC, SXA_OP_SBC};

   sequence mul_go_s;
      exec_ok && op == SXA_OP_MUL;
   endsequence
   sequence mul_end_s;
      st_q.wb && st_q.result == 32'(st_q.mcand * st_q.mplier);
   endsequence

   cond_gate_a: assert property (
      st_q.state == SXA_EXEC && !cond_ok |=> $stable(st_q.csw) && $stable(st_q.pc) && !st_q.wb)
      else $error("failed condition changed state");
   user_lock_a: assert property (
      exec_ok && op == SXA_OP_MSR && !st_q.insn[`SXA_F_RBIT] && is_user
      |=> st_q.csw[23:0] == $past(st_q.csw[23:0]))
      else $error("user mode status write altered low bits");
   mask_flag_a: assert property (
      exec_ok && op == SXA_OP_MSR && !st_q.insn[`SXA_F_RBIT] && st_q.insn[19]
      |=> st_q.csw[31:24] == $past(msr_opnd[31:24]))
      else $error("flag byte not written by status write");
   mul_low_a: assert property (mul_go_s |-> ##[4:7] mul_end_s)
      else $error("multiply result missing or wrong");
   mul_cv_a: assert property (
      st_q.state == SXA_MULW && mif.done && sflag
      |=> st_q.csw[`SXA_F_CV] == $past(st_q.csw[`SXA_F_CV]) && st_q.csw[31] == st_q.result[31])
      else $error("multiply flags wrong");
   logic_carry_a: assert property (
      exec_ok && (op == SXA_OP_MVN || op == SXA_OP_ORR) && sflag && rd != `SXA_PC_IDX
      |=> st_q.csw[`SXA_FC] == $past(sh_c) && st_q.csw[`SXA_FV] == $past(st_q.csw[`SXA_FV]))
      else $error("logic op carry or overflow wrong");
   sbc_value_a: assert property (
      exec_ok && op == SXA_OP_SBC && rd != `SXA_PC_IDX
      |=> st_q.wb && st_q.result == $past(st_q.opnd_a - sh_v - 32'(!st_q.csw[`SXA_FC])))
      else $error("subtract with carry result wrong");
   pc_branch_a: assert property (
      exec_ok && dp_op && rd == `SXA_PC_IDX && !sflag
      |=> st_q.pc == $past(alu_res) && $stable(st_q.csw) && !st_q.wb)
      else $error("pc destination branch wrong");
   pc_restore_a: assert property (
      exec_ok && dp_op && rd == `SXA_PC_IDX && sflag && has_ssw
      |=> st_q.pc == $past(alu_res) && st_q.csw == $past(st_q.ssw))
      else $error("pc destination restore wrong");
   apb_pulse_a: assert property ($rose(pready_o) |=> !pready_o)
      else $error("pready held longer than one cycle");
endmodule

//--- test/sxa_tb.sv
// Purpose: self-checking bench for the status/ALU unit over APB
// Assumes: this bench is the only APB master, one instruction in flight
// Notes: expected results and flag words are worked out by hand per case
`timescale 1ns/1ps
`include "sxa_map.svh"
module testbench;
   import sxa_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] paddr_i = 8'h00;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] prdata_o, result_o, pc_o, csw_o;
   logic pready_o, pslverr_o, wb_valid_o;
   logic [3:0] wb_dest_o;
   logic [31:0] d;
   int failures = 0;
   int n_compared = 0;
   int wbcnt = 0;

   sxa_core dut (
      .clk_i(clk_i), .rst_i(rst_i), .paddr_i(paddr_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .wb_valid_o(wb_valid_o), .wb_dest_o(wb_dest_o), .result_o(result_o),
      .pc_o(pc_o), .csw_o(csw_o)
   );

   initial
   begin
      forever #4 clk_i = ~clk_i;
   end

   // Write-back pulses, so a skipped instruction can be seen to write nothing
   always @(posedge clk_i)
   begin
      if (wb_valid_o === 1'b1)
         wbcnt <= wbcnt + 1;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      if (failures == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // One APB transfer; read data lands in d. Idle edge after it avoids double drives.
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
      psel_i <= 1'b1;
      paddr_i <= a;
      pwrite_i <= w;
      pwdata_i <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      // No fixed wait assumed; only the watchdog ends a hang
      do
         @(posedge clk_i);
      while (pready_o !== 1'b1);
      d = prdata_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask

   // Start an instruction and poll busy until it clears
   task automatic run(input logic [31:0] insn);
      apb(`SXA_A_INSN, 1'b1, insn);
      d = 32'h1;
      while (d[0] !== 1'b0)
         apb(`SXA_A_STAT, 1'b0, 32'h0);
      @(posedge clk_i);
   endtask

   function automatic logic [31:0] dp(input logic [3:0] c, input logic i, input logic [3:0] op,
      input logic s, input logic [3:0] rd, input logic [11:0] o);
      return {c, 2'b00, i, op, s, 4'h0, rd, o};
   endfunction

   function automatic logic [31:0] mu(input logic [3:0] rd);
      return {4'hE, 6'h00, 1'b0, 1'b1, rd, 8'h00, 4'h9, 4'h0};
   endfunction

   function automatic logic [31:0] ms(input logic i, input logic [3:0] m, input logic [11:0] o);
      return {4'hE, 2'b00, i, 2'b10, 1'b0, 2'b10, m, 4'hF, o};
   endfunction

   // Operand a feeds both first operand and multiplicand, b shifter and multiplier
   task automatic alu(input logic [31:0] insn, input logic [31:0] a, input logic [31:0] b,
      input logic c, input logic [31:0] cin, input logic [31:0] er, input logic [31:0] ec);
      apb(`SXA_A_CSW, 1'b1, cin);
      apb(`SXA_A_OPNDA, 1'b1, a);
      apb(`SXA_A_MCAND, 1'b1, a);
      apb(`SXA_A_SHOP, 1'b1, b);
      apb(`SXA_A_MPLIER, 1'b1, b);
      apb(`SXA_A_SHC, 1'b1, {31'h0, c});
      run(insn);
      check(result_o, er);
      check(csw_o, ec);
   endtask

   task automatic t_logic();
      alu(dp(4'hE, 1'b0, `SXA_OPC_ORR, 1'b1, 4'h2, 12'h000), 32'h8000_00F0, 32'h0000_000F,
         1'b1, 32'h1000_0013, 32'h8000_00FF, 32'hB000_0013);
      check({28'h0, wb_dest_o}, 32'h2);
      alu(dp(4'hE, 1'b1, `SXA_OPC_MVN, 1'b1, 4'h3, 12'h43C), 32'h0, 32'h0,
         1'b1, 32'h1000_0013, 32'hC3FF_FFFF, 32'h9000_0013);
      alu(dp(4'hE, 1'b0, `SXA_OPC_MVN, 1'b1, 4'h3, 12'h000), 32'h0, 32'hFFFF_FFFF,
         1'b0, 32'h2000_0013, 32'h0, 32'h4000_0013);
   endtask

   task automatic t_arith();
      alu(dp(4'hE, 1'b0, `SXA_OPC_RSB, 1'b1, 4'h5, 12'h000), 32'h1, 32'h8000_0000,
         1'b0, 32'h0000_0013, 32'h7FFF_FFFF, 32'h3000_0013);
      alu(dp(4'hE, 1'b0, `SXA_OPC_SBC, 1'b1, 4'h6, 12'h000), 32'h5, 32'h2,
         1'b0, 32'h0000_0013, 32'h2, 32'h2000_0013);
      alu(dp(4'hE, 1'b0, `SXA_OPC_RSC, 1'b1, 4'h7, 12'h000), 32'h2, 32'h3,
         1'b0, 32'h0000_0013, 32'h0, 32'h6000_0013);
      alu(dp(4'hE, 1'b0, `SXA_OPC_RSC, 1'b1, 4'h7, 12'h000), 32'hFFFF_FFFF, 32'h7FFF_FFFF,
         1'b0, 32'h2000_0013, 32'h8000_0000, 32'h9000_0013);
   endtask

   task automatic t_mul();
      alu(mu(4'h8), 32'hFFFF_FFFF, 32'h3, 1'b0, 32'h3000_0013,
         32'hFFFF_FFFD, 32'hB000_0013);
      // Upper multiplier bytes only: the low word of the product wraps to zero and sets Z
      alu(mu(4'h9), 32'h0001_0000, 32'h0101_0000, 1'b0, 32'h3000_0013,
         32'h0, 32'h7000_0013);
   endtask

   task automatic t_cond();
      int n;
      n = wbcnt;
      alu(dp(4'h0, 1'b0, `SXA_OPC_ORR, 1'b1, 4'h4, 12'h000), 32'h1234, 32'h0,
         1'b1, 32'h0000_0013, 32'h0, 32'h0000_0013);
      check(wbcnt, n);
      alu(dp(4'h1, 1'b0, `SXA_OPC_ORR, 1'b1, 4'h4, 12'h000), 32'h1234, 32'h0,
         1'b1, 32'h0000_0013, 32'h1234, 32'h2000_0013);
   endtask

   task automatic t_status();
      logic [31:0] e;
      for (int k = 0; k < 4; k++)
      begin
         e = 32'h0000_0013;
         e[8*k +: 8] = 8'hA5;
         alu(ms(1'b0, 4'h1 << k, 12'h000), 32'hA5A5_A5A5, 32'h0, 1'b0, 32'h0000_0013,
            32'h1234, e);
      end
      alu(ms(1'b1, 4'h8, 12'h4F0), 32'h0, 32'h0, 1'b0, 32'h0000_0013,
         32'h1234, 32'hF000_0013);
      alu(ms(1'b0, 4'hF, 12'h000), 32'h5000_00D3, 32'h0, 1'b0, 32'h0000_0010,
         32'h1234, 32'h5000_0010);
   endtask

   // Read the status word, set N in a general value, write it back
   task automatic t_rmw();
      apb(`SXA_A_CSW, 1'b1, 32'h0000_0013);
      apb(`SXA_A_CSW, 1'b0, 32'h0);
      check(d, 32'h0000_0013);
      check({31'h0, pslverr_o}, 32'h0);
      apb(`SXA_A_MCAND, 1'b1, d | 32'h8000_0000);
      run(ms(1'b0, 4'h8, 12'h000));
      check(csw_o, 32'h8000_0013);
   endtask

   task automatic t_pc();
      apb(`SXA_A_SSW, 1'b1, 32'h9000_001F);
      apb(`SXA_A_CSW, 1'b1, 32'h0000_0013);
      apb(`SXA_A_OPNDA, 1'b1, 32'h0000_0100);
      apb(`SXA_A_SHOP, 1'b1, 32'h0000_0004);
      run(dp(4'hE, 1'b0, `SXA_OPC_ORR, 1'b0, `SXA_PC_IDX, 12'h000));
      check(pc_o, 32'h0000_0104);
      check(csw_o, 32'h0000_0013);
      apb(`SXA_A_SHOP, 1'b1, 32'hFFFF_FEFF);
      run(dp(4'hE, 1'b0, `SXA_OPC_MVN, 1'b1, `SXA_PC_IDX, 12'h000));
      check(pc_o, 32'h0000_0100);
      check(csw_o, 32'h9000_001F);
   endtask

   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_logic();
      t_arith();
      t_mul();
      t_cond();
      t_status();
      t_rmw();
      t_pc();
      tally_and_finish();
   end

   // Whole run is well under a thousand cycles; this is far beyond it
   initial
   begin
      #200000;
      failures++;
      tally_and_finish();
   end
endmodule
